// [brg_ctrl_regs.sv]
/*
 Bridge window and control register slice of a switch port acting as a
 PCI-to-PCI bridge. Holds the prefetchable window upper parts, I/O upper
 halves, capability pointer, interrupt line/pin and bridge control, and
 drives forwarding decisions and the secondary hot reset.
 Assumes a single-cycle config write/read port and that the lower base and
 limit fields are supplied by neighbouring register logic on the same clock.
*/
// Summary of operation
// - Prefetch limit low nibble is read-only 0001b, meaning 64-bit.
// - Writable 12-bit prefetch limit gives bits 31:20; bits 19:0 ones.
// - 32-bit register at 28h gives prefetch base bits 63:32, reset 0.
// - 32-bit register at 2ch gives prefetch limit bits 63:32, reset 0.
// - Memory forwarding decided by the full 64-bit prefetch window.
// - Low half of 30h gives I/O base bits 31:16, reset 0.
// - High half of 30h gives I/O limit bits 31:16, reset 0.
// - Capability pointer is read-only, pointing at power management.
// - Interrupt line byte is plain storage, reset 0, no hardware effect.
// - Interrupt pin is read-only, reset 0, overridable by side-band load on any port.
// - Parity response bit clear ignores poisoned TLPs, set reports them.
// - Error forward bit gates secondary error messages to primary.
// - ISA bit clear forwards whole I/O window; set sends ISA aliases up.
// - VGA bit forwards legacy VGA memory and I/O ranges, else ignores.
// - VGA decode bit picks 10-bit (clear) or 16-bit (set) I/O match.
// - Secondary reset bit on downstream port asserts its port reset.
// - Secondary reset bit on upstream port resets every downstream port.
// - Legacy timing bits 21, 23-27 read zero and ignore writes.
`timescale 1ns/100ps
module brg_ctrl_regs
   import brg_pkg::*;
#(
   parameter int NUM_DOWN = 3,
   parameter bit IS_UPSTREAM = 1'b0
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Configuration access port
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   // Side-band override of the interrupt pin byte
   input wire logic int_pin_load_i,
   input wire logic [7:0] int_pin_val_i,
   // Lower halves owned by neighbouring registers
   input wire logic [11:0] pref_base_low_i,
   input wire logic [15:0] io_base_low_i,
   input wire logic [15:0] io_limit_low_i,
   // Transaction under decision
   input wire logic [63:0] mem_addr_i,
   input wire logic [31:0] io_addr_i,
   // Poisoned TLP and error messages from the secondary side
   input wire logic sec_poison_i,
   input wire logic sec_err_msg_i,
   // Forwarding decisions and reset outputs
   output logic pref_fwd_o,
   output logic io_fwd_down_o,
   output logic io_fwd_up_o,
   output logic vga_fwd_o,
   output logic poison_report_o,
   output logic err_msg_fwd_o,
   output logic hot_reset_o,
   output logic [NUM_DOWN-1:0] port_rst_n_o
);
   // Stored register state
   logic [11:0] pref_lim_q, pref_lim_d;
   logic [31:0] pref_base_hi_q, pref_base_hi_d;
   logic [31:0] pref_lim_hi_q, pref_lim_hi_d;
   logic [15:0] io_base_hi_q, io_base_hi_d;
   logic [15:0] io_lim_hi_q, io_lim_hi_d;
   logic [7:0] int_line_q, int_line_d;
   logic [7:0] int_pin_q, int_pin_d;
   logic perr_q, perr_d;
   logic serr_fwd_q, serr_fwd_d;
   logic isa_q, isa_d;
   logic vga_q, vga_d;
   logic vga16_q, vga16_d;
   logic sec_rst_q, sec_rst_d;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic [6:0] out_q, out_d;
   logic [NUM_DOWN-1:0] rst_n_q, rst_n_d;
   // Window bounds and comparator results
   logic [63:0] pref_base_full, pref_lim_full;
   logic pref_hit, io_hit;
   logic vga_mem_hit, vga_io_hit, isa_alias;
   logic [9:0] vga_io10;
   logic vga_io_upper_ok;
   logic [31:0] ctrl_word;
   logic [31:0] wmask;

   // Byte-enable mask for writes
   always_comb begin
      wmask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}},
               {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
   end

   // Register write decode; only writable fields are stored
   always_comb begin
      pref_lim_d = pref_lim_q;
      pref_base_hi_d = pref_base_hi_q;
      pref_lim_hi_d = pref_lim_hi_q;
      io_base_hi_d = io_base_hi_q;
      io_lim_hi_d = io_lim_hi_q;
      int_line_d = int_line_q;
      int_pin_d = int_pin_q;
      perr_d = perr_q;
      serr_fwd_d = serr_fwd_q;
      isa_d = isa_q;
      vga_d = vga_q;
      vga16_d = vga16_q;
      sec_rst_d = sec_rst_q;
      if (int_pin_load_i) begin
         int_pin_d = int_pin_val_i;
      end
      if (cfg_wr_i) begin
         case (cfg_addr_i)
            BRG_OFF_PREF_LIM: begin
               // Bits 19:16 are hardwired and never stored
               pref_lim_d = (pref_lim_q & ~wmask[31:20])
                  | (cfg_wdata_i[31:20] & wmask[31:20]);
            end
            BRG_OFF_PREF_BASE_HI: begin
               pref_base_hi_d = (pref_base_hi_q & ~wmask)
                  | (cfg_wdata_i & wmask);
            end
            BRG_OFF_PREF_LIM_HI: begin
               pref_lim_hi_d = (pref_lim_hi_q & ~wmask)
                  | (cfg_wdata_i & wmask);
            end
            BRG_OFF_IO_HI: begin
               io_base_hi_d = (io_base_hi_q & ~wmask[15:0])
                  | (cfg_wdata_i[15:0] & wmask[15:0]);
               io_lim_hi_d = (io_lim_hi_q & ~wmask[31:16])
                  | (cfg_wdata_i[31:16] & wmask[31:16]);
            end
            BRG_OFF_INT_CTRL: begin
               if (cfg_be_i[0]) begin
                  int_line_d = cfg_wdata_i[7:0];
               end
               if (cfg_be_i[2]) begin
                  perr_d = cfg_wdata_i[BRG_BIT_PERR];
                  serr_fwd_d = cfg_wdata_i[BRG_BIT_SERR_FWD];
                  isa_d = cfg_wdata_i[BRG_BIT_ISA];
                  vga_d = cfg_wdata_i[BRG_BIT_VGA];
                  vga16_d = cfg_wdata_i[BRG_BIT_VGA16];
                  sec_rst_d = cfg_wdata_i[BRG_BIT_SEC_RST];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Register storage
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pref_lim_q <= BRG_RST_LIM12;
         pref_base_hi_q <= BRG_RST_HI32;
         pref_lim_hi_q <= BRG_RST_HI32;
         io_base_hi_q <= BRG_RST_IO16;
         io_lim_hi_q <= BRG_RST_IO16;
         int_line_q <= BRG_RST_INT_LINE;
         int_pin_q <= BRG_RST_INT_PIN;
         perr_q <= 1'b0;
         serr_fwd_q <= 1'b0;
         isa_q <= 1'b0;
         vga_q <= 1'b0;
         vga16_q <= 1'b0;
         sec_rst_q <= 1'b0;
      end else begin
         pref_lim_q <= pref_lim_d;
         pref_base_hi_q <= pref_base_hi_d;
         pref_lim_hi_q <= pref_lim_hi_d;
         io_base_hi_q <= io_base_hi_d;
         io_lim_hi_q <= io_lim_hi_d;
         int_line_q <= int_line_d;
         int_pin_q <= int_pin_d;
         perr_q <= perr_d;
         serr_fwd_q <= serr_fwd_d;
         isa_q <= isa_d;
         vga_q <= vga_d;
         vga16_q <= vga16_d;
         sec_rst_q <= sec_rst_d;
      end
   end

   // Bridge control dword; legacy timing bits stay zero
   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[7:0] = int_line_q;
      ctrl_word[15:8] = int_pin_q;
      ctrl_word[BRG_BIT_PERR] = perr_q;
      ctrl_word[BRG_BIT_SERR_FWD] = serr_fwd_q;
      ctrl_word[BRG_BIT_ISA] = isa_q;
      ctrl_word[BRG_BIT_VGA] = vga_q;
      ctrl_word[BRG_BIT_VGA16] = vga16_q;
      ctrl_word[BRG_BIT_SEC_RST] = sec_rst_q;
   end

   // Read mux, answered one cycle after the request
   always_comb begin
      rdata_d = 32'h0000_0000;
      rvalid_d = cfg_rd_i;
      if (cfg_rd_i) begin
         case (cfg_addr_i)
            BRG_OFF_PREF_LIM: begin
               rdata_d = {pref_lim_q, BRG_PREF_64BIT, 16'h0000};
            end
            BRG_OFF_PREF_BASE_HI: begin
               rdata_d = pref_base_hi_q;
            end
            BRG_OFF_PREF_LIM_HI: begin
               rdata_d = pref_lim_hi_q;
            end
            BRG_OFF_IO_HI: begin
               rdata_d = {io_lim_hi_q, io_base_hi_q};
            end
            BRG_OFF_CAP_PTR: begin
               rdata_d = {24'h00_0000, BRG_CAP_PTR_VAL};
            end
            BRG_OFF_INT_CTRL: begin
               rdata_d = ctrl_word;
            end
            default: begin
               rdata_d = 32'h0000_0000;
            end
         endcase
      end
   end

   // Read answer registers
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Assemble full 64-bit prefetch bounds
   always_comb begin
      pref_base_full = {pref_base_hi_q, pref_base_low_i, 20'h00000};
      pref_lim_full = {pref_lim_hi_q, pref_lim_q, BRG_LIM_LOW_ONES};
   end

   // Prefetchable window comparator
   brg_window_cmp #(
      .W(64)
   ) u_pref_cmp (
      .base_i(pref_base_full),
      .limit_i(pref_lim_full),
      .addr_i(mem_addr_i),
      .hit_o(pref_hit)
   );

   // I/O window comparator, 4KB granular low half
   brg_window_cmp #(
      .W(32)
   ) u_io_cmp (
      .base_i({io_base_hi_q, io_base_low_i}),
      .limit_i({io_lim_hi_q, io_limit_low_i}),
      .addr_i(io_addr_i),
      .hit_o(io_hit)
   );

   // VGA and ISA alias decode
   always_comb begin
      vga_mem_hit = (mem_addr_i >= BRG_VGA_MEM_LO)
         && (mem_addr_i <= BRG_VGA_MEM_HI);
      vga_io10 = io_addr_i[9:0];
      // 16-bit decode also needs bits 15:10 zero; 10-bit ignores them
      vga_io_upper_ok = (io_addr_i[31:16] == 16'h0000)
         && (!vga16_q || io_addr_i[15:10] == 6'h00);
      vga_io_hit = vga_io_upper_ok
         && (((vga_io10 >= BRG_VGA_IO_A_LO) && (vga_io10 <= BRG_VGA_IO_A_HI))
         || ((vga_io10 >= BRG_VGA_IO_B_LO) && (vga_io10 <= BRG_VGA_IO_B_HI)));
      isa_alias = (io_addr_i[31:16] == 16'h0000)
         && (io_addr_i[9:8] != BRG_ISA_LOW_QTR);
   end

   // Registered forwarding decisions and reset outputs
   always_comb begin
      out_d = 7'h00;
      out_d[0] = pref_hit;
      out_d[1] = io_hit && !(isa_q && isa_alias);
      out_d[2] = io_hit && isa_q && isa_alias;
      out_d[3] = vga_q && (vga_mem_hit || vga_io_hit);
      out_d[4] = perr_q && sec_poison_i;
      out_d[5] = serr_fwd_q && sec_err_msg_i;
      out_d[6] = sec_rst_q;
      for (int i = 0; i < NUM_DOWN; i++) begin
         // Upstream port drives all; a downstream port owns index 0 only
         if (IS_UPSTREAM || i == 0) begin
            rst_n_d[i] = !sec_rst_q;
         end else begin
            rst_n_d[i] = 1'b1;
         end
      end
   end

   // Output flops
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         out_q <= 7'h00;
         rst_n_q <= '1;
      end else begin
         out_q <= out_d;
         rst_n_q <= rst_n_d;
      end
   end

   // Port outputs
   assign cfg_rdata_o = rdata_q;
   assign cfg_rvalid_o = rvalid_q;
   assign pref_fwd_o = out_q[0];
   assign io_fwd_down_o = out_q[1];
   assign io_fwd_up_o = out_q[2];
   assign vga_fwd_o = out_q[3];
   assign poison_report_o = out_q[4];
   assign err_msg_fwd_o = out_q[5];
   assign hot_reset_o = out_q[6];
   assign port_rst_n_o = rst_n_q;
endmodule

// [brg_ctrl_regs_checker.sv]
/* Checker for the bridge register slice, bound to its ports.
   Assumes one clock domain and one-cycle answers. */
`timescale 1ns/100ps
module brg_ctrl_regs_checker
   import brg_pkg::*;
#(
   parameter int NUM_DOWN = 3,
   parameter bit IS_UPSTREAM = 1'b0
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Config port
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic cfg_rvalid_o,
   // Events and decisions
   input wire logic sec_poison_i,
   input wire logic sec_err_msg_i,
   input wire logic io_fwd_down_o,
   input wire logic io_fwd_up_o,
   input wire logic poison_report_o,
   input wire logic err_msg_fwd_o,
   input wire logic hot_reset_o,
   input wire logic [NUM_DOWN-1:0] port_rst_n_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);
   // Read of one offset, and a control write carrying the reset bit
   sequence rd_s(a);
      cfg_rd_i && cfg_addr_i == a;
   endsequence
   sequence ctl_wr_s(v);
      cfg_wr_i && cfg_addr_i == BRG_OFF_INT_CTRL && cfg_be_i[2]
         && cfg_wdata_i[BRG_BIT_SEC_RST] == v;
   endsequence
   cap_ptr_a: assert property (rd_s(BRG_OFF_CAP_PTR) |=>
      cfg_rvalid_o && cfg_rdata_o == {24'h0, BRG_CAP_PTR_VAL})
      else $error("capability pointer wrong");
   lim_nibble_a: assert property (rd_s(BRG_OFF_PREF_LIM) |=>
      cfg_rdata_o[19:0] == {BRG_PREF_64BIT, 16'h0})
      else $error("limit low nibble wrong");
   legacy_zero_a: assert property (rd_s(BRG_OFF_INT_CTRL) |=>
      cfg_rdata_o[21] == 1'b0 && cfg_rdata_o[31:23] == 9'h0)
      else $error("legacy bits not zero");
   rst_set_a: assert property (ctl_wr_s(1'b1) |-> ##2
      hot_reset_o && !port_rst_n_o[0])
      else $error("hot reset not raised");
   rst_clear_a: assert property (ctl_wr_s(1'b0) |-> ##2
      !hot_reset_o && port_rst_n_o[0])
      else $error("hot reset not dropped");
   rst_fanout_a: assert property (port_rst_n_o == (IS_UPSTREAM ?
      {NUM_DOWN{~hot_reset_o}} : {{(NUM_DOWN-1){1'b1}}, ~hot_reset_o}))
      else $error("port reset fan-out wrong");
   io_excl_a: assert property (!(io_fwd_down_o && io_fwd_up_o))
      else $error("I/O sent both ways");
   poison_gate_a: assert property (poison_report_o |->
      $past(sec_poison_i)) else $error("poison report without cause");
   err_gate_a: assert property (err_msg_fwd_o |->
      $past(sec_err_msg_i)) else $error("error sent without cause");
endmodule

bind brg_ctrl_regs brg_ctrl_regs_checker #(
   .NUM_DOWN(NUM_DOWN),
   .IS_UPSTREAM(IS_UPSTREAM)
) i_brg_ctrl_regs_checker (
   .clock_i(clock_i),
   .sys_rst_i(sys_rst_i),
   .cfg_wr_i(cfg_wr_i),
   .cfg_rd_i(cfg_rd_i),
   .cfg_addr_i(cfg_addr_i),
   .cfg_be_i(cfg_be_i),
   .cfg_wdata_i(cfg_wdata_i),
   .cfg_rdata_o(cfg_rdata_o),
   .cfg_rvalid_o(cfg_rvalid_o),
   .sec_poison_i(sec_poison_i),
   .sec_err_msg_i(sec_err_msg_i),
   .io_fwd_down_o(io_fwd_down_o),
   .io_fwd_up_o(io_fwd_up_o),
   .poison_report_o(poison_report_o),
   .err_msg_fwd_o(err_msg_fwd_o),
   .hot_reset_o(hot_reset_o),
   .port_rst_n_o(port_rst_n_o)
);

// [brg_ctrl_regs_test.sv]
/* Self-checking bench for the bridge register slice: config access,
   windows, VGA, error gating and hot reset. Assumes one clock. */
`timescale 1ns/100ps
module brg_ctrl_regs_test;
   import brg_pkg::*;
   // Design ports and bench state
   logic clock_i, sys_rst_i, cfg_wr_i, cfg_rd_i, int_pin_load_i;
   logic sec_poison_i, sec_err_msg_i, cfg_rvalid_o, pref_fwd_o;
   logic io_fwd_down_o, io_fwd_up_o, vga_fwd_o, poison_report_o;
   logic err_msg_fwd_o, hot_reset_o, hot_reset_up;
   logic [2:0] port_rst_n_o, port_rst_n_up;
   logic [3:0] cfg_be_i;
   logic [7:0] cfg_addr_i, int_pin_val_i;
   logic [11:0] pref_base_low_i;
   logic [15:0] io_base_low_i, io_limit_low_i;
   logic [31:0] cfg_wdata_i, cfg_rdata_o, io_addr_i, got;
   logic [63:0] mem_addr_i;
   int err_total = 0;
   int tests_run = 0;
   // Address tables: prefetch, I/O with expected {down, up}, VGA
   logic [63:0] pt [5] = '{64'h1_0fff_ffff, 64'h1_1000_0000,
      64'h1_200f_ffff, 64'h1_2010_0000, 64'h0_1500_0000};
   logic [31:0] it [3] = '{32'h1100, 32'h1000, 32'h2000};
   logic [1:0] et [6] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0};
   logic [47:0] vt [13] = '{48'h00_a0000_0000_0, 48'h08_a0000_0000_1,
      48'h08_bffff_0000_1, 48'h08_c0000_0000_0, 48'h08_9ffff_0000_0,
      48'h08_00000_03b0_1, 48'h08_00000_03bb_1, 48'h08_00000_03bc_0,
      48'h08_00000_03df_1, 48'h08_00000_03e0_0, 48'h08_00000_07b0_1,
      48'h18_00000_07b0_0, 48'h18_00000_03c0_1};

   // Device under test
   brg_ctrl_regs #(.NUM_DOWN(3), .IS_UPSTREAM(1'b0)) i_brg_ctrl_regs (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .cfg_wr_i(cfg_wr_i),
      .cfg_rd_i(cfg_rd_i),
      .cfg_addr_i(cfg_addr_i),
      .cfg_be_i(cfg_be_i),
      .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o),
      .cfg_rvalid_o(cfg_rvalid_o),
      .int_pin_load_i(int_pin_load_i),
      .int_pin_val_i(int_pin_val_i),
      .pref_base_low_i(pref_base_low_i),
      .io_base_low_i(io_base_low_i),
      .io_limit_low_i(io_limit_low_i),
      .mem_addr_i(mem_addr_i),
      .io_addr_i(io_addr_i),
      .sec_poison_i(sec_poison_i),
      .sec_err_msg_i(sec_err_msg_i),
      .pref_fwd_o(pref_fwd_o),
      .io_fwd_down_o(io_fwd_down_o),
      .io_fwd_up_o(io_fwd_up_o),
      .vga_fwd_o(vga_fwd_o),
      .poison_report_o(poison_report_o),
      .err_msg_fwd_o(err_msg_fwd_o),
      .hot_reset_o(hot_reset_o),
      .port_rst_n_o(port_rst_n_o)
   );

   // Upstream flavour on the same inputs, watched for reset fan-out
   brg_ctrl_regs #(.NUM_DOWN(3), .IS_UPSTREAM(1'b1)) i_brg_ctrl_regs_up (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .cfg_wr_i(cfg_wr_i),
      .cfg_rd_i(cfg_rd_i),
      .cfg_addr_i(cfg_addr_i),
      .cfg_be_i(cfg_be_i),
      .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(),
      .cfg_rvalid_o(),
      .int_pin_load_i(int_pin_load_i),
      .int_pin_val_i(int_pin_val_i),
      .pref_base_low_i(pref_base_low_i),
      .io_base_low_i(io_base_low_i),
      .io_limit_low_i(io_limit_low_i),
      .mem_addr_i(mem_addr_i),
      .io_addr_i(io_addr_i),
      .sec_poison_i(sec_poison_i),
      .sec_err_msg_i(sec_err_msg_i),
      .pref_fwd_o(),
      .io_fwd_down_o(),
      .io_fwd_up_o(),
      .vga_fwd_o(),
      .poison_report_o(),
      .err_msg_fwd_o(),
      .hot_reset_o(hot_reset_up),
      .port_rst_n_o(port_rst_n_up)
   );

   // 125 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // One config write, one cycle long
   task automatic wr(input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d);
      @(negedge clock_i);
      cfg_wr_i = 1'b1;
      cfg_addr_i = a;
      cfg_be_i = be;
      cfg_wdata_i = d;
      @(negedge clock_i);
      cfg_wr_i = 1'b0;
   endtask

   // One config read; answer must stand in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(negedge clock_i);
      cfg_rd_i = 1'b1;
      cfg_addr_i = a;
      @(negedge clock_i);
      cfg_rd_i = 1'b0;
      chk(cfg_rvalid_o === 1'b1 ? cfg_rdata_o : ~e, e);
   endtask

   // Present an address pair; decisions follow one edge later
   task automatic dec(input logic [63:0] m, input logic [31:0] i);
      @(negedge clock_i);
      mem_addr_i = m;
      io_addr_i = i;
      @(negedge clock_i);
   endtask

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (20000) @(posedge clock_i);
      $display("CHECK FAILED t=%0t run did not finish", $time);
      err_total++;
      summarize();
   end

   // Main sequence
   initial begin
      sys_rst_i = 1'b1;
      {cfg_wr_i, cfg_rd_i, int_pin_load_i, sec_poison_i, sec_err_msg_i,
         cfg_addr_i, cfg_be_i, cfg_wdata_i, int_pin_val_i, pref_base_low_i,
         io_base_low_i, io_limit_low_i, mem_addr_i, io_addr_i} = '0;
      repeat (10) @(posedge clock_i);
      @(negedge clock_i);
      sys_rst_i = 1'b0;
      rd(8'h24, 32'h0001_0000);
      rd(8'h28, 32'h0);
      rd(8'h2c, 32'h0);
      rd(8'h30, 32'h0);
      rd(8'h34, 32'h40);
      rd(8'h3c, 32'h0);
      rd(8'h38, 32'h0);
      wr(8'h24, 4'hf, '1);
      rd(8'h24, 32'hfff1_0000);
      wr(8'h34, 4'hf, '1);
      rd(8'h34, 32'h40);
      wr(8'h28, 4'hf, 32'h1);
      wr(8'h2c, 4'hf, 32'h1);
      rd(8'h28, 32'h1);
      rd(8'h2c, 32'h1);
      wr(8'h30, 4'hf, 32'hdead_beef);
      wr(8'h30, 4'h3, 32'h0);
      rd(8'h30, 32'hdead_0000);
      wr(8'h3c, 4'hf, '1);
      rd(8'h3c, 32'h005f_00ff);
      chk({28'h0, hot_reset_o, port_rst_n_o}, 32'he);
      chk({28'h0, hot_reset_up, port_rst_n_up}, 32'h8);
      wr(8'h3c, 4'hf, 32'h0);
      rd(8'h3c, 32'h0);
      chk({28'h0, hot_reset_o, port_rst_n_o}, 32'h7);
      chk({28'h0, hot_reset_up, port_rst_n_up}, 32'h7);
      // Side-band pin load, then a config write that must not touch it
      @(negedge clock_i);
      int_pin_load_i = 1'b1;
      int_pin_val_i = 8'h01;
      @(negedge clock_i);
      int_pin_load_i = 1'b0;
      wr(8'h3c, 4'h2, 32'h0000_5500);
      rd(8'h3c, 32'h0000_0100);
      // Poison and error messages, gated off then on
      for (int en = 0; en < 2; en++) begin
         wr(8'h3c, 4'h4, en ? 32'h0003_0000 : 32'h0);
         @(negedge clock_i);
         {sec_poison_i, sec_err_msg_i} = 2'b11;
         @(negedge clock_i);
         {sec_poison_i, sec_err_msg_i} = 2'b00;
         got = {30'h0, poison_report_o, err_msg_fwd_o};
         chk(got, 32'(3 * en));
      end
      // Prefetch window 1_1000_0000 .. 1_200f_ffff, edges inclusive
      pref_base_low_i = 12'h100;
      wr(8'h24, 4'hc, 32'h2000_0000);
      for (int i = 0; i < 5; i++) begin
         dec(pt[i], 32'h0);
         chk({31'h0, pref_fwd_o}, 32'(i == 1 || i == 2));
      end
      // I/O window 1000 .. 1fff, ISA off then on
      io_base_low_i = 16'h1000;
      io_limit_low_i = 16'h1fff;
      wr(8'h30, 4'hf, 32'h0);
      for (int k = 0; k < 6; k++) begin
         wr(8'h3c, 4'h4, (k > 2) ? 32'h0004_0000 : 32'h0);
         dec(64'h0, it[k % 3]);
         got = {30'h0, io_fwd_down_o, io_fwd_up_o};
         chk(got, {30'h0, et[k]});
      end
      // Upper halves lift the window above the first 64KB
      wr(8'h30, 4'hf, 32'h0001_0001);
      dec(64'h0, 32'h0001_1100);
      chk({30'h0, io_fwd_down_o, io_fwd_up_o}, 32'h2);
      // VGA memory and I/O ranges, 10- and 16-bit decode
      for (int v = 0; v < 13; v++) begin
         wr(8'h3c, 4'h4, {8'h0, vt[v][47:40], 16'h0});
         dec({44'h0, vt[v][39:20]}, {16'h0, vt[v][19:4]});
         chk({31'h0, vga_fwd_o}, {31'h0, vt[v][0]});
      end
      // Mid-run reset returns stored and loaded fields to zero
      @(negedge clock_i);
      sys_rst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      sys_rst_i = 1'b0;
      rd(8'h30, 32'h0);
      rd(8'h3c, 32'h0);
      summarize();
   end
endmodule

// [brg_pkg.sv]
/*
 Package for the bridge window and control register slice: config word
 offsets, field positions, reset values and fixed read-only patterns.
 Assumes a dword-addressed configuration access port with byte enables.
*/
package brg_pkg;
   // Configuration dword byte offsets
   localparam logic [7:0] BRG_OFF_PREF_LIM = 8'h24;
   localparam logic [7:0] BRG_OFF_PREF_BASE_HI = 8'h28;
   localparam logic [7:0] BRG_OFF_PREF_LIM_HI = 8'h2c;
   localparam logic [7:0] BRG_OFF_IO_HI = 8'h30;
   localparam logic [7:0] BRG_OFF_CAP_PTR = 8'h34;
   localparam logic [7:0] BRG_OFF_INT_CTRL = 8'h3c;
   // Fixed read-only values
   localparam logic [3:0] BRG_PREF_64BIT = 4'h1;
   localparam logic [7:0] BRG_CAP_PTR_VAL = 8'h40;
   localparam logic [19:0] BRG_LIM_LOW_ONES = 20'hfffff;
   localparam logic [9:0] BRG_IO_LIM_LOW_ONES = 10'h3ff;
   // Reset values
   localparam logic [31:0] BRG_RST_HI32 = 32'h0000_0000;
   localparam logic [15:0] BRG_RST_IO16 = 16'h0000;
   localparam logic [11:0] BRG_RST_LIM12 = 12'h000;
   localparam logic [7:0] BRG_RST_INT_LINE = 8'h00;
   localparam logic [7:0] BRG_RST_INT_PIN = 8'h00;
   // Bridge control bit positions within dword 3ch
   localparam int BRG_BIT_PERR = 16;
   localparam int BRG_BIT_SERR_FWD = 17;
   localparam int BRG_BIT_ISA = 18;
   localparam int BRG_BIT_VGA = 19;
   localparam int BRG_BIT_VGA16 = 20;
   localparam int BRG_BIT_SEC_RST = 22;
   // Legacy VGA ranges
   localparam logic [63:0] BRG_VGA_MEM_LO = 64'h0000_0000_000a_0000;
   localparam logic [63:0] BRG_VGA_MEM_HI = 64'h0000_0000_000b_ffff;
   localparam logic [9:0] BRG_VGA_IO_A_LO = 10'h3b0;
   localparam logic [9:0] BRG_VGA_IO_A_HI = 10'h3bb;
   localparam logic [9:0] BRG_VGA_IO_B_LO = 10'h3c0;
   localparam logic [9:0] BRG_VGA_IO_B_HI = 10'h3df;
   // ISA alias: top 768 bytes of each 1KB block inside the first 64KB
   localparam logic [1:0] BRG_ISA_LOW_QTR = 2'h0;
endpackage

// [brg_window_cmp.sv]
/*
 Inclusive window comparator: hit when base <= addr <= limit.
 Assumes all three values are presented on the same clock.
*/
`timescale 1ns/100ps
module brg_window_cmp #(
   parameter int W = 64
) (
   // Window bounds and address
   input wire logic [W-1:0] base_i,
   input wire logic [W-1:0] limit_i,
   input wire logic [W-1:0] addr_i,
   // Result
   output logic hit_o
);
   // Both bounds inclusive
   always_comb begin
      hit_o = (addr_i >= base_i) && (addr_i <= limit_i);
   end
endmodule
